// ===== verilog/dac_wave_and_dual_conversion.sv
/*
 * Digital control for a two-channel converter: held data, noise and triangle
 * wave addition, delayed output load, DMA requests and underrun flags.
 * Assumes triggers already selected per channel and synchronous to clk;
 * output words drain through a two-entry buffer toward the analog stage.
 */
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Underrun when a trigger arrives while that channel's DMA request still pends.
// - Underrun sets a sticky flag; interrupt only when that channel enables it.
// - Wave select 01 with trigger enable selects noise generation.
// - Noise register holds 0xAAA after preload, before any update.
// - Noise register advances once per conversion, three cycles after trigger.
// - An all-zero noise register gets a one injected.
// - Masked noise added to held data and stored as the output word.
// - Clearing wave select resets the noise state.
// - Wave select 1x with trigger enable selects triangle; amplitude from mask field.
// - Triangle counter steps three cycles after trigger, sum loads output.
// - Triangle counts up to amplitude, down to zero, and repeats.
// - Clearing wave select resets the triangle counter.
// - Mask field writes are ignored while the channel is enabled.
// - Dual data writes load held data of both channels at once.
// - Separate per-channel held data writes reach every dual mode too.
// - Independent triggers load only their own channel, three cycles later.
// - Independent noise: add, load, then advance that channel's register.
// - Each channel keeps its own triangle counter and amplitude.
// - A shared trigger loads both outputs after three cycles.
// - Shared noise trigger loads both sums together, then advances both.
// - DMA request on trigger with DMA enabled, held until acknowledge.
// - Mask code n unmasks bits n..0, amplitude 2^(n+1)-1, capped at 12 bits.
// - Without trigger enable, written held data reaches output one cycle later.
module dac_wave_and_dual_conversion
    import dac_wave_pkg::*;
#(
    parameter int BUF_DEPTH = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Channel configuration
    input wire logic [CH_N-1:0] enable,
    input wire logic [CH_N-1:0] trigger_enable,
    input wire logic [CH_N-1:0][1:0] wave_select,
    input wire logic [CH_N-1:0] dma_request_enable,
    input wire logic [CH_N-1:0] underrun_irq_enable,
    input wire logic [CH_N-1:0][MASK_AMPLITUDE_W-1:0] mask_amplitude_wdata,
    input wire logic [CH_N-1:0] mask_amplitude_we,
    // Held data writes
    input wire logic [CH_N-1:0] held_data_we,
    input wire logic [CH_N-1:0][DATA_W-1:0] held_data_wdata,
    input wire logic dual_data_we,
    input wire dual_word_t dual_data_wdata,
    // Selected triggers, one-cycle pulses
    input wire logic [CH_N-1:0] trigger,
    // DMA handshake
    output logic [CH_N-1:0] dma_request,
    input wire logic [CH_N-1:0] dma_ack,
    // Status
    input wire logic [CH_N-1:0] underrun_flag_clear,
    output logic [CH_N-1:0] underrun_flag,
    output logic [CH_N-1:0] underrun_irq,
    output logic [CH_N-1:0][MASK_AMPLITUDE_W-1:0] mask_amplitude,
    output logic [CH_N-1:0][DATA_W-1:0] held_data_word,
    output logic [CH_N-1:0][DATA_W-1:0] channel_output_word,
    output logic [CH_N-1:0] conversion_stall,
    // Output word stream toward the analog stage
    output logic [CH_N-1:0] out_valid,
    input wire logic [CH_N-1:0] out_ready,
    output logic [CH_N-1:0][DATA_W-1:0] out_data
);

    // ------------------------------------------------------------------
    // Per-channel control
    // ------------------------------------------------------------------
    localparam int DLY_W = $clog2(TRIG_DELAY + 1);
    localparam int CNT_W = $clog2(BUF_DEPTH + 1);
    localparam logic [DLY_W-1:0] DLY_LOAD = DLY_W'(TRIG_DELAY);
    localparam logic [DLY_W-1:0] DLY_DIRECT = DLY_W'(DIRECT_DELAY);
    localparam logic [DLY_W-1:0] DLY_ONE = DLY_W'(1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(BUF_DEPTH);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;

    genvar g;
    generate
        for (g = 0; g < CH_N; g++) begin : gen_ch
            // Decode and datapath
            wave_mode_t mode;
            logic [DATA_W-1:0] wave_mask;
            logic [DATA_W-1:0] wave_val;
            logic [DATA_W:0] sum;
            logic [DATA_W-1:0] sum_sat;
            logic [DATA_W-1:0] noise_nxt;
            logic feedback;
            logic load_now;
            logic fire;
            logic underrun_hit;

            // Channel state, one owner process each
            logic [DATA_W-1:0] out_word_r;
            logic [DATA_W-1:0] noise_r;
            logic [DATA_W-1:0] tri_r;
            logic tri_down_r;
            logic [DLY_W-1:0] delay_r;
            logic [DATA_W-1:0] held_r;
            logic [MASK_AMPLITUDE_W-1:0] mask_amplitude_r;
            logic dma_req_r;
            logic underrun_r;

            // Output buffer
            logic [BUF_DEPTH-1:0][DATA_W-1:0] buf_r;
            logic [CNT_W-1:0] cnt_r;
            logic [CNT_W-1:0] cnt_nxt;
            logic [CNT_W-1:0] wr_idx;
            logic buf_in_ready;
            logic pop;

            // ----------------------------------------------------------
            // Wave mode and mask
            // ----------------------------------------------------------
            // Mode select
            always_comb begin
                if (!trigger_enable[g] || wave_select[g] == WAVE_OFF) begin
                    mode = MODE_DIRECT;
                end else if (wave_select[g] == WAVE_NOISE) begin
                    mode = MODE_NOISE;
                end else begin
                    mode = MODE_TRIANGLE;
                end
            end

            always_comb begin
                if (mask_amplitude_r >= MASK_AMPLITUDE_TOP) begin
                    wave_mask = DATA_MAX;
                end else begin
                    wave_mask = DATA_MAX >> (DATA_W - 1 - int'(mask_amplitude_r));
                end
            end

            // ----------------------------------------------------------
            // Sum and noise step
            // ----------------------------------------------------------
            // Saturating sum of held data and wave
            always_comb begin
                unique case (mode)
                    MODE_NOISE: wave_val = noise_r & wave_mask;
                    MODE_TRIANGLE: wave_val = tri_r;
                    MODE_DIRECT: wave_val = DATA_ZERO;
                    default: wave_val = DATA_ZERO;
                endcase
                sum = {1'b0, held_r} + {1'b0, wave_val};
                sum_sat = sum[DATA_W] ? DATA_MAX : sum[DATA_W-1:0];
            end

            always_comb begin
                feedback = noise_r[TAP_A] ^ noise_r[TAP_B]
                    ^ noise_r[TAP_C] ^ noise_r[TAP_D];
                noise_nxt = {noise_r[DATA_W-2:0], feedback};
                if (noise_nxt == DATA_ZERO) begin
                    noise_nxt = NOISE_INJECT;
                end
            end

            // ----------------------------------------------------------
            // Trigger delay and output load
            // ----------------------------------------------------------
            assign fire = trigger_enable[g] && trigger[g];
            assign load_now = (delay_r == DLY_ONE) && buf_in_ready;

            // Delay from trigger or write to load
            always_ff @(posedge clk) begin
                if (reset) begin
                    delay_r <= '0;
                end else if (fire) begin
                    delay_r <= DLY_LOAD;
                end else if (!trigger_enable[g] && (held_data_we[g] || dual_data_we)) begin
                    delay_r <= DLY_DIRECT;
                end else if (delay_r > DLY_ONE || load_now) begin
                    delay_r <= delay_r - DLY_ONE;
                end
            end

            always_ff @(posedge clk) begin
                if (reset) begin
                    out_word_r <= DATA_ZERO;
                end else if (load_now) begin
                    out_word_r <= sum_sat;
                end
            end

            // ----------------------------------------------------------
            // Wave generators
            // ----------------------------------------------------------
            // Noise register
            always_ff @(posedge clk) begin
                if (reset || wave_select[g] == WAVE_OFF) begin
                    noise_r <= NOISE_SEED;
                end else if (load_now && mode == MODE_NOISE) begin
                    noise_r <= noise_nxt;
                end
            end

            always_ff @(posedge clk) begin
                if (reset || wave_select[g] == WAVE_OFF) begin
                    tri_r <= DATA_ZERO;
                    tri_down_r <= 1'b0;
                end else if (load_now && mode == MODE_TRIANGLE) begin
                    if (!tri_down_r) begin
                        if (tri_r < wave_mask) begin
                            tri_r <= tri_r + 1'b1;
                        end else begin
                            tri_down_r <= 1'b1;
                            tri_r <= tri_r - 1'b1;
                        end
                    end else if (tri_r > DATA_ZERO) begin
                        tri_r <= tri_r - 1'b1;
                    end else begin
                        tri_down_r <= 1'b0;
                        tri_r <= tri_r + 1'b1;
                    end
                end
            end

            // ----------------------------------------------------------
            // Held data and mask field
            // ----------------------------------------------------------
            // Held data, dual word loads both
            always_ff @(posedge clk) begin
                if (reset) begin
                    held_r <= DATA_ZERO;
                end else if (held_data_we[g]) begin
                    held_r <= held_data_wdata[g];
                end else if (dual_data_we) begin
                    held_r <= (g == 0) ? dual_data_wdata.ch1 : dual_data_wdata.ch2;
                end
            end

            always_ff @(posedge clk) begin
                if (reset) begin
                    mask_amplitude_r <= '0;
                end else if (mask_amplitude_we[g] && !enable[g]) begin
                    mask_amplitude_r <= mask_amplitude_wdata[g];
                end
            end

            // ----------------------------------------------------------
            // DMA request and underrun
            // ----------------------------------------------------------
            // A pending request means the previous transfer is unserviced
            assign underrun_hit = fire && dma_req_r && !dma_ack[g];

            always_ff @(posedge clk) begin
                if (reset) begin
                    dma_req_r <= 1'b0;
                end else if (fire && dma_request_enable[g]) begin
                    dma_req_r <= 1'b1;
                end else if (dma_ack[g]) begin
                    dma_req_r <= 1'b0;
                end
            end

            // Sticky underrun, set wins over clear
            always_ff @(posedge clk) begin
                if (reset) begin
                    underrun_r <= 1'b0;
                end else if (underrun_hit) begin
                    underrun_r <= 1'b1;
                end else if (underrun_flag_clear[g]) begin
                    underrun_r <= 1'b0;
                end
            end

            // ----------------------------------------------------------
            // Output buffer
            // ----------------------------------------------------------
            // A full buffer still takes a word when the head leaves
            assign buf_in_ready = (cnt_r != CNT_FULL) || pop;
            assign pop = (cnt_r != CNT_ZERO) && out_ready[g];
            // The new word lands behind the head that shifts out
            assign wr_idx = pop ? cnt_r - CNT_ONE : cnt_r;

            // Occupancy after push and pop
            always_comb begin
                cnt_nxt = cnt_r;
                if (load_now && !pop) begin
                    cnt_nxt = cnt_r + CNT_ONE;
                end else if (!load_now && pop) begin
                    cnt_nxt = cnt_r - CNT_ONE;
                end
            end

            always_ff @(posedge clk) begin
                if (reset) begin
                    cnt_r <= CNT_ZERO;
                end else begin
                    cnt_r <= cnt_nxt;
                end
            end

            always_ff @(posedge clk) begin
                if (reset) begin
                    buf_r <= '0;
                end else begin
                    if (pop) begin
                        for (int i = 0; i < BUF_DEPTH - 1; i++) begin
                            buf_r[i] <= buf_r[i+1];
                        end
                    end
                    if (load_now) begin
                        buf_r[wr_idx] <= sum_sat;
                    end
                end
            end

            // ----------------------------------------------------------
            // Ports
            // ----------------------------------------------------------
            assign channel_output_word[g] = out_word_r;
            assign held_data_word[g] = held_r;
            assign mask_amplitude[g] = mask_amplitude_r;
            assign dma_request[g] = dma_req_r;
            assign underrun_flag[g] = underrun_r;
            assign underrun_irq[g] = underrun_r && underrun_irq_enable[g];
            assign conversion_stall[g] = (delay_r == DLY_ONE) && !buf_in_ready;
            assign out_valid[g] = (cnt_r != CNT_ZERO);
            assign out_data[g] = buf_r[0];
        end
    endgenerate

endmodule : dac_wave_and_dual_conversion

`default_nettype wire

// ===== verilog/dac_wave_pkg.sv
/*
 * Shared constants and carrier types for the two-channel converter control.
 * Assumes a single clock domain with synchronous active-high reset.
 */
package dac_wave_pkg;
    localparam int DATA_W = 12;
    localparam int CH_N = 2;
    localparam int MASK_AMPLITUDE_W = 4;
    localparam int TRIGGER_SOURCE_SELECT_W = 3;
    localparam int TRIG_DELAY = 3;
    localparam int DIRECT_DELAY = 1;
    localparam logic [DATA_W-1:0] NOISE_SEED = 12'haaa;
    localparam logic [DATA_W-1:0] DATA_MAX = 12'hfff;
    localparam logic [DATA_W-1:0] DATA_ZERO = 12'h000;
    localparam logic [DATA_W-1:0] NOISE_INJECT = 12'h001;
    localparam logic [MASK_AMPLITUDE_W-1:0] MASK_AMPLITUDE_TOP = 4'hb;
    localparam logic [1:0] WAVE_OFF = 2'b00;
    localparam logic [1:0] WAVE_NOISE = 2'b01;
    localparam int TAP_A = 11;
    localparam int TAP_B = 5;
    localparam int TAP_C = 3;
    localparam int TAP_D = 0;

    typedef enum logic [1:0] {
        MODE_DIRECT,
        MODE_NOISE,
        MODE_TRIANGLE
    } wave_mode_t;

    typedef struct packed {
        logic enable;
        logic trigger_enable;
        logic [1:0] wave_select;
        logic dma_request_enable;
        logic underrun_irq_enable;
        logic [MASK_AMPLITUDE_W-1:0] mask_amplitude;
    } channel_cfg_t;

    typedef struct packed {
        logic [DATA_W-1:0] ch2;
        logic [DATA_W-1:0] ch1;
    } dual_word_t;
endpackage : dac_wave_pkg

// ===== tb/dma_partner.sv
/* DMA controller stand-in: acknowledges each request after a set lag.
   Assumes requests are levels held until acknowledged. */
`timescale 1ns/10ps
`default_nettype none
module dma_partner (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Request and acknowledge
    input wire logic [1:0] dma_request,
    input wire logic [7:0] lag,
    output logic [1:0] dma_ack
);
    logic [1:0][7:0] wait_r;
    always_ff @(posedge clk) begin
        for (int c = 0; c < 2; c++) begin
            dma_ack[c] <= !reset && dma_request[c] && !dma_ack[c] && wait_r[c] >= lag;
            wait_r[c] <= (reset || !dma_request[c] || dma_ack[c]) ? 8'h00 : wait_r[c] + 8'h01;
        end
    end
endmodule : dma_partner
`default_nettype wire

// ===== tb/dac_wave_and_dual_conversion_chk.sv
/* Port-level checks on the converter control.
   Bound to the top module; sees its ports only. */
`timescale 1ns/10ps
`default_nettype none
module dac_wave_chk
    import dac_wave_pkg::*;
#(
    parameter int BUF_DEPTH = 2
) (
    // Inputs
    input wire logic clk,
    input wire logic reset,
    input wire logic [CH_N-1:0] enable,
    input wire logic [CH_N-1:0] trigger_enable,
    input wire logic [CH_N-1:0][1:0] wave_select,
    input wire logic [CH_N-1:0] dma_request_enable,
    input wire logic [CH_N-1:0] underrun_irq_enable,
    input wire logic [CH_N-1:0] mask_amplitude_we,
    input wire logic [CH_N-1:0] held_data_we,
    input wire logic dual_data_we,
    input wire logic [CH_N-1:0] trigger,
    input wire logic [CH_N-1:0] dma_ack,
    input wire logic [CH_N-1:0] underrun_flag_clear,
    input wire logic [CH_N-1:0] out_ready,
    // Outputs
    input wire logic [CH_N-1:0] dma_request,
    input wire logic [CH_N-1:0] underrun_flag,
    input wire logic [CH_N-1:0] underrun_irq,
    input wire logic [CH_N-1:0][MASK_AMPLITUDE_W-1:0] mask_amplitude,
    input wire logic [CH_N-1:0][DATA_W-1:0] held_data_word,
    input wire logic [CH_N-1:0][DATA_W-1:0] channel_output_word,
    input wire logic [CH_N-1:0] conversion_stall,
    input wire logic [CH_N-1:0] out_valid,
    input wire logic [CH_N-1:0][DATA_W-1:0] out_data
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    for (genvar c = 0; c < CH_N; c++) begin : g_ch
        sequence s_trig;
            trigger[c] && trigger_enable[c] && wave_select[c] == WAVE_OFF;
        endsequence
        sequence s_quiet;
            (!trigger[c] && !held_data_we[c] && !dual_data_we && !conversion_stall[c])[*3];
        endsequence
        sequence s_direct;
            held_data_we[c] && !trigger_enable[c]
                ##1 !held_data_we[c] && !dual_data_we && !conversion_stall[c];
        endsequence
        AST_TRIG_LOAD: assert property (s_trig ##1 s_quiet |=>
            channel_output_word[c] == held_data_word[c])
            else $error("trigger load wrong");
        AST_DIRECT_LOAD: assert property (s_direct |=>
            channel_output_word[c] == held_data_word[c])
            else $error("direct load wrong");
        AST_UNDERRUN_SET: assert property (trigger[c] && trigger_enable[c]
            && dma_request[c] && !dma_ack[c] |=> underrun_flag[c])
            else $error("underrun missed");
        AST_FLAG_CLEAR: assert property (underrun_flag_clear[c] && !trigger[c]
            |=> !underrun_flag[c])
            else $error("flag not cleared");
        AST_IRQ: assert property (underrun_irq[c] == (underrun_flag[c] && underrun_irq_enable[c]))
            else $error("irq wrong");
        AST_DMA_RISE: assert property (trigger[c] && trigger_enable[c]
            && dma_request_enable[c] |=> dma_request[c])
            else $error("no dma request");
        AST_DMA_HOLD: assert property (dma_request[c] && !dma_ack[c] |=> dma_request[c])
            else $error("dma request dropped");
        AST_MASK_AMPLITUDE_LOCK: assert property (enable[c] && mask_amplitude_we[c]
            |=> $stable(mask_amplitude[c]))
            else $error("mask written while enabled");
        AST_BUF_HOLD: assert property (out_valid[c] && !out_ready[c] |=> out_valid[c] && $stable(out_data[c]))
            else $error("buffer head lost");
    end
endmodule : dac_wave_chk
bind dac_wave_and_dual_conversion dac_wave_chk #(.BUF_DEPTH(BUF_DEPTH)) u_chk (.clk, .reset,
    .enable, .trigger_enable, .wave_select, .dma_request_enable, .underrun_irq_enable,
    .mask_amplitude_we, .held_data_we, .dual_data_we, .trigger, .dma_ack, .underrun_flag_clear,
    .out_ready, .dma_request, .underrun_flag, .underrun_irq, .mask_amplitude, .held_data_word,
    .channel_output_word, .conversion_stall, .out_valid, .out_data);
`default_nettype wire

// ===== tb/dac_wave_and_dual_conversion_tb.sv
/* Self-checking bench for the converter control.
   Assumes the checker binds itself and the DMA stand-in answers requests. */
`timescale 1ns/10ps
`default_nettype none
module dac_wave_and_dual_conversion_tb;
    import dac_wave_pkg::*;
    logic clk = 0, reset = 1, dual_data_we = 0;
    logic [CH_N-1:0] enable = '0, trigger_enable = '0, dma_request_enable = '0, dma_ack;
    logic [CH_N-1:0] underrun_irq_enable = '0, mask_amplitude_we = '0, held_data_we = '0;
    logic [CH_N-1:0] trigger = '0, underrun_flag_clear = '0, out_ready = '1, dma_request;
    logic [CH_N-1:0] underrun_flag, underrun_irq, conversion_stall, out_valid;
    logic [CH_N-1:0][1:0] wave_select = '0;
    logic [CH_N-1:0][MASK_AMPLITUDE_W-1:0] mask_amplitude_wdata = '0, mask_amplitude;
    logic [CH_N-1:0][DATA_W-1:0] held_data_wdata = '0, out_data;
    dual_word_t dual_data_wdata = '0;
    logic [7:0] lag = 8'h00;
    logic [DATA_W-1:0] exp_q[CH_N][$], hv[CH_N], lf[CH_N], tv[CH_N], amp[CH_N];
    logic [DATA_W-1:0] exp_w;
    logic up[CH_N];
    int errors = 0, checks = 0, cyc = 0, seed = 32'h1286_8fa5;
    dac_wave_and_dual_conversion #(.BUF_DEPTH(2)) dut (.clk, .reset, .enable, .trigger_enable,
        .wave_select, .dma_request_enable, .underrun_irq_enable, .mask_amplitude_wdata,
        .mask_amplitude_we, .held_data_we, .held_data_wdata, .dual_data_we, .dual_data_wdata,
        .trigger, .dma_request, .dma_ack, .underrun_flag_clear, .underrun_flag, .underrun_irq,
        .mask_amplitude, .held_data_word(), .channel_output_word(), .conversion_stall,
        .out_valid, .out_ready, .out_data);
    dma_partner far_end (.clk, .reset, .dma_request, .lag, .dma_ack);
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic cmp(string name, logic [DATA_W-1:0] e, logic [DATA_W-1:0] s);
        checks++;
        if (s !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, e, s);
        end
    endtask : cmp
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish
    function automatic logic [DATA_W-1:0] sat(logic [DATA_W-1:0] a, logic [DATA_W-1:0] b);
        logic [DATA_W:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[DATA_W] ? DATA_MAX : s[DATA_W-1:0];
    endfunction : sat
    task automatic restart();
        for (int c = 0; c < CH_N; c++) begin
            lf[c] = NOISE_SEED;
            tv[c] = DATA_ZERO;
            up[c] = 1'b1;
        end
    endtask : restart
    // Pulse triggers and note the words the models predict
    task automatic fire(logic [CH_N-1:0] m);
        for (int c = 0; c < CH_N; c++) begin
            if (m[c] && wave_select[c] == WAVE_NOISE) begin
                exp_q[c].push_back(sat(hv[c], lf[c] & amp[c]));
                lf[c] = {lf[c][DATA_W-2:0], lf[c][TAP_A] ^ lf[c][TAP_B]
                    ^ lf[c][TAP_C] ^ lf[c][TAP_D]};
                if (lf[c] == DATA_ZERO) lf[c] = NOISE_INJECT;
            end else if (m[c] && wave_select[c][1]) begin
                exp_q[c].push_back(sat(hv[c], tv[c]));
                up[c] = (tv[c] == amp[c]) ? 1'b0 : (tv[c] == DATA_ZERO) ? 1'b1 : up[c];
                tv[c] = up[c] ? tv[c] + 1'b1 : tv[c] - 1'b1;
            end else if (m[c]) begin
                exp_q[c].push_back(hv[c]);
            end
        end
        trigger = m;
        tick(1);
        trigger = '0;
        tick(5);
    endtask : fire
    task automatic put(logic [CH_N-1:0] sel, logic dual);
        for (int c = 0; c < CH_N; c++) begin
            held_data_wdata[c] = DATA_W'($random(seed));
            if (sel[c] || dual) hv[c] = held_data_wdata[c];
            if ((sel[c] || dual) && !trigger_enable[c]) exp_q[c].push_back(hv[c]);
        end
        dual_data_wdata = held_data_wdata;
        held_data_we = dual ? 2'b00 : sel;
        dual_data_we = dual;
        tick(1);
        held_data_we = '0;
        dual_data_we = 0;
        tick(3);
    endtask : put
    always @(posedge clk) begin
        cyc++;
        if (cyc > 5000) begin
            errors++;
            tally_and_finish();
        end
        for (int c = 0; c < CH_N; c++) begin
            if (!reset && out_valid[c] === 1'b1 && out_ready[c]) begin
                exp_w = exp_q[c].size() > 0 ? exp_q[c].pop_front() : ~out_data[c];
                cmp("out_data", exp_w, out_data[c]);
            end
        end
    end
    initial begin
        restart();
        tick(20);
        reset = 0;
        mask_amplitude_wdata = {4'hc, 4'($random(seed) & 3)};
        mask_amplitude_we = '1;
        tick(1);
        enable = '1;
        amp[0] = DATA_MAX >> (4'hb - mask_amplitude_wdata[0]);
        amp[1] = DATA_MAX;
        mask_amplitude_wdata = '0;
        tick(1);
        mask_amplitude_we = '0;
        tick(1);
        cmp("mask", 12'h00c, 12'(mask_amplitude[1]));
        put(2'b11, 0);
        put(2'b10, 0);
        put(2'b00, 1);
        trigger_enable = '1;
        put(2'b00, 1);
        fire(2'b11);
        fire(2'b01);
        wave_select = {WAVE_NOISE, 2'b10};
        repeat (12) fire(2'b01);
        repeat (12) fire(2'b10);
        repeat (24) fire(2'b11);
        wave_select = '0;
        tick(1);
        restart();
        wave_select = {WAVE_NOISE, 2'b11};
        repeat (4) fire(2'b11);
        out_ready = '0;
        repeat (3) fire(2'b01);
        cmp("stall", 12'h001, 12'(conversion_stall[0]));
        out_ready = '1;
        lag = 8'h14;
        dma_request_enable = '1;
        underrun_irq_enable = 2'b01;
        repeat (2) fire(2'b11);
        cmp("flag", 12'h003, 12'(underrun_flag));
        cmp("irq", 12'h001, 12'(underrun_irq));
        tick(30);
        underrun_flag_clear = '1;
        tick(1);
        underrun_flag_clear = '0;
        lag = 8'h00;
        repeat (3) fire(2'b11);
        cmp("flag clear", 12'h000, 12'(underrun_flag));
        tick(10);
        cmp("pending", 12'h000, 12'(exp_q[0].size() + exp_q[1].size()));
        tally_and_finish();
    end
endmodule : dac_wave_and_dual_conversion_tb
`default_nettype wire
